// *** design/dcf_pkg.sv ***
package dcf_pkg;

  // Data path and offset widths
  localparam int DATA_W   = 18;
  localparam int OFFS_W   = 12;
  localparam int CNT_W    = 13;                 // Holds counts up to 4096

  // Default offsets per depth class
  localparam logic [OFFS_W-1:0] OFFS_31  = 12'h01F;
  localparam logic [OFFS_W-1:0] OFFS_63  = 12'h03F;
  localparam logic [OFFS_W-1:0] OFFS_127 = 12'h07F;
  localparam int SMALL_DEPTH = 256;             // Depth that uses the 31/31 defaults

  // Strap pattern {first_load, read_expansion_in, write_expansion_in} for fall-through
  localparam logic [2:0] STRAP_FIRST_WORD_FALL_THROUGH = 3'h1;

  // Pin synchroniser depth and bundle layout
  localparam int SYNC_STAGES = 2;
  localparam int PIN_W       = 10;
  localparam int PIN_WCLK    = 0;
  localparam int PIN_RCLK    = 1;
  localparam int PIN_WEN     = 2;
  localparam int PIN_REN     = 3;
  localparam int PIN_LD      = 4;
  localparam int PIN_OE      = 5;
  localparam int PIN_RST     = 6;
  localparam int PIN_FL      = 7;
  localparam int PIN_RXI     = 8;
  localparam int PIN_WXI     = 9;

  // Wishbone register map (byte addresses)
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] ADDR_CTRL    = 8'h00;
  localparam logic [ADR_W-1:0] ADDR_STATUS  = 8'h04;
  localparam logic [ADR_W-1:0] ADDR_OFFSETS = 8'h08;
  localparam logic [ADR_W-1:0] ADDR_COUNT   = 8'h0C;

  // Control fields
  localparam int CTRL_SYNC_BIT = 0;             // 1: synchronous almost flags
  localparam logic CTRL_SYNC_RST = 1'b0;

  // Status fields
  localparam int ST_EF   = 0;
  localparam int ST_FF   = 1;
  localparam int ST_PAE  = 2;
  localparam int ST_PAF  = 3;
  localparam int ST_HF   = 4;
  localparam int ST_FIRST_WORD_FALL_THROUGH = 5;
  localparam int ST_SYNC = 6;
  localparam int ST_OV   = 7;

  // Offsets register: empty offset low half, full offset high half
  localparam int OFFS_FULL_LSB = 16;

  typedef enum logic {
    DCF_MODE_STD  = 1'b0,
    DCF_MODE_FIRST_WORD_FALL_THROUGH = 1'b1
  } dcf_mode_e;

endpackage : dcf_pkg

// *** design/dcf_sync.sv ***
`timescale 1ns/1ps
module dcf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_i, // System clock
  input  wire logic         rst_i, // Synchronous reset
  input  wire logic [W-1:0] d_i,   // Asynchronous input
  output logic      [W-1:0] q_o    // Synchronised output
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= '0;
      q_o    <= '0;
    end else begin
      meta_q <= d_i;
      q_o    <= meta_q;
    end
  end

endmodule : dcf_sync

// *** design/dcf_fifo.sv ***
`timescale 1ns/1ps
// Overview of operation
// - Straps sampled during reset choose timing mode
// - Standard mode: data shown only after read
// - Read enable at read edge outputs oldest
// - Fall-through: first word appears without read
// - Write enable low stores data per edge
// - Standard: empty flag rises after first write
// - Almost-empty rises at empty offset plus one
// - Half-full falls above half depth
// - Almost-full falls at depth minus offset
// - Default full offset 31 or 127
// - Full flag at depth, writes blocked
// - First read when full clears full
// - Reads return almost-full and half-full high
// - Almost-empty falls at offset or below
// - Default empty offset 31 or 63
// - Reading last word sets empty, blocks reads
// - Read enable ignored while empty
// - Full on write edge, empty on read
// - Sync timing: each almost flag one clock
// - Output enable gates only output drivers
// - Fall-through: output ready and input ready
// - Offset load alternates empty, full registers
// - Async almost flags set/clear opposite clocks
module dcf_fifo import dcf_pkg::*; #(
  parameter int DEPTH = 256                        // 256, 512, 1024 or 4096
) (
  input  wire logic              clk_i,            // System clock
  input  wire logic              rst_i,            // Synchronous reset, active high
  input  wire logic              reset_n_i,        // Device reset pin, active low
  input  wire logic              first_load_strap_n_i,   // Mode strap
  input  wire logic              read_expansion_in_n_i,  // Mode strap
  input  wire logic              write_expansion_in_n_i, // Mode strap
  input  wire logic              wclk_i,           // Write clock pin
  input  wire logic              wen_n_i,          // Write enable, active low
  input  wire logic              offset_load_n_i,  // Offset load, active low
  input  wire logic [DATA_W-1:0] data_i,           // Write data
  input  wire logic              rclk_i,           // Read clock pin
  input  wire logic              ren_n_i,          // Read enable, active low
  input  wire logic              oe_n_i,           // Output enable, active low
  output logic      [DATA_W-1:0] data_o,           // Read data
  output logic                   data_oe_o,        // High while data_o is driven
  output logic                   empty_flag_n_o,   // Empty, or output_ready_n in fall-through
  output logic                   full_flag_n_o,    // Full, or input_ready_n in fall-through
  output logic                   almost_empty_n_o, // Almost empty, active low
  output logic                   almost_full_n_o,  // Almost full, active low
  output logic                   half_full_n_o,    // Half full, active low
  input  wire logic              wb_cyc_i,         // Wishbone cycle
  input  wire logic              wb_stb_i,         // Wishbone strobe
  input  wire logic              wb_we_i,          // Wishbone write
  input  wire logic [ADR_W-1:0]  wb_adr_i,         // Wishbone byte address
  input  wire logic [3:0]        wb_sel_i,         // Wishbone byte selects
  input  wire logic [31:0]       wb_dat_i,         // Wishbone write data
  output logic      [31:0]       wb_dat_o,         // Wishbone read data
  output logic                   wb_ack_o          // Wishbone acknowledge
);

  localparam int AW = $clog2(DEPTH);
  localparam int PW = AW + 1;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);
  localparam logic [CNT_W-1:0] HALF_C  = CNT_W'(DEPTH / 2);
  localparam logic [OFFS_W-1:0] EOFF_DEF = (DEPTH == SMALL_DEPTH) ? OFFS_31 : OFFS_63;
  localparam logic [OFFS_W-1:0] FOFF_DEF = (DEPTH == SMALL_DEPTH) ? OFFS_31 : OFFS_127;

  // Gray to binary for pointers seen by the far side
  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction : gray2bin

  // Pin synchronisers: every pin passes two flops before use
  logic [PIN_W-1:0]  pin_raw;
  logic [PIN_W-1:0]  pin_s;
  logic [DATA_W-1:0] data_s;
  assign pin_raw = {write_expansion_in_n_i, read_expansion_in_n_i, first_load_strap_n_i,
                    reset_n_i, oe_n_i, offset_load_n_i, ren_n_i, wen_n_i, rclk_i, wclk_i};

  dcf_sync #(.W(PIN_W + DATA_W)) u_pin_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   ({data_i, pin_raw}),
    .q_o   ({data_s, pin_s})
  );

  // Clock edge detection on the sampled link clocks
  logic wclk_q;
  logic rclk_q;
  wire  w_edge = pin_s[PIN_WCLK] & ~wclk_q;
  wire  r_edge = pin_s[PIN_RCLK] & ~rclk_q;
  wire  dev_rst = rst_i | ~pin_s[PIN_RST];
  wire  wen_s   = ~pin_s[PIN_WEN];
  wire  ren_s   = ~pin_s[PIN_REN];
  wire  ld_s    = ~pin_s[PIN_LD];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wclk_q <= 1'b0;
      rclk_q <= 1'b0;
    end else begin
      wclk_q <= pin_s[PIN_WCLK];
      rclk_q <= pin_s[PIN_RCLK];
    end
  end

  // Mode latched while the device reset pin is held low
  dcf_mode_e mode_q;
  logic      sync_flags_q;
  wire       first_word_fall_through = (mode_q == DCF_MODE_FIRST_WORD_FALL_THROUGH);
  wire       strap_first_word_fall_through = ({pin_s[PIN_FL], pin_s[PIN_RXI], pin_s[PIN_WXI]} == STRAP_FIRST_WORD_FALL_THROUGH);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= DCF_MODE_STD;
    end else if (!pin_s[PIN_RST]) begin
      mode_q <= strap_first_word_fall_through ? DCF_MODE_FIRST_WORD_FALL_THROUGH : DCF_MODE_STD;
    end
  end

  // Storage and pointers
  logic [DATA_W-1:0] mem_q [DEPTH];
  logic [PW-1:0]     wptr_q;
  logic [PW-1:0]     rptr_q;
  logic [PW-1:0]     wgray_q;
  logic [PW-1:0]     rgray_q;
  logic [PW-1:0]     wgray_r;
  logic [PW-1:0]     rgray_w;
  logic [OFFS_W-1:0] eoff_q;
  logic [OFFS_W-1:0] foff_q;
  logic              offsel_q;

  // Gray pointers pass through two flops to the opposite side
  dcf_sync #(.W(PW)) u_w2r (
    .clk_i (clk_i),
    .rst_i (dev_rst),
    .d_i   (wgray_q),
    .q_o   (wgray_r)
  );

  dcf_sync #(.W(PW)) u_r2w (
    .clk_i (clk_i),
    .rst_i (dev_rst),
    .d_i   (rgray_q),
    .q_o   (rgray_w)
  );

  // Write side occupancy; lags reads, so it never underestimates
  wire [PW-1:0] rbin_w    = gray2bin(rgray_w);
  wire [PW-1:0] occ_w     = wptr_q - rbin_w;
  wire          full_mem  = ({{(CNT_W-PW){1'b0}}, occ_w} == DEPTH_C);
  wire          ld_wr     = w_edge & wen_s & ld_s;
  wire          wr_ok     = w_edge & wen_s & ~ld_s & ~full_mem;
  wire [PW-1:0] wptr_d    = wptr_q + PW'(wr_ok);
  wire [CNT_W-1:0] occ_wn = {{(CNT_W-PW){1'b0}}, PW'(wptr_d - rbin_w)};

  // Read side occupancy; lags writes, so empty never clears early
  logic              ov_q;
  logic [DATA_W-1:0] dout_q;
  wire [PW-1:0] wbin_r    = gray2bin(wgray_r);
  wire          empty_mem = (wbin_r == rptr_q);
  wire          rd_std    = r_edge & ~first_word_fall_through & ren_s & ~empty_mem;
  wire          rd_fw     = r_edge & first_word_fall_through & ~empty_mem & (~ov_q | ren_s);
  wire          rd_mem    = rd_std | rd_fw;
  wire [PW-1:0] rptr_d    = rptr_q + PW'(rd_mem);
  wire          ov_d      = rd_fw ? 1'b1 : ((r_edge & first_word_fall_through & ren_s) ? 1'b0 : ov_q);
  wire [CNT_W-1:0] occ_rn = {{(CNT_W-PW){1'b0}}, PW'(wbin_r - rptr_d)} + CNT_W'(ov_d);

  // Thresholds follow the depth and the programmed offsets
  wire [CNT_W-1:0] eoff_c  = {{(CNT_W-OFFS_W){1'b0}}, eoff_q};
  wire [CNT_W-1:0] paf_thr = DEPTH_C - {{(CNT_W-OFFS_W){1'b0}}, foff_q};
  wire             pae_w   = occ_wn > eoff_c;
  wire             pae_r   = occ_rn > eoff_c;
  wire             paf_w   = occ_wn >= paf_thr;
  wire             paf_r   = occ_rn >= paf_thr;

  // Memory write, needs no reset
  always_ff @(posedge clk_i) begin
    if (wr_ok) begin
      mem_q[wptr_q[AW-1:0]] <= data_s;
    end
  end

  // Write pointer and offset registers
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      wptr_q   <= '0;
      wgray_q  <= '0;
      eoff_q   <= EOFF_DEF;
      foff_q   <= FOFF_DEF;
      offsel_q <= 1'b0;
    end else begin
      wptr_q  <= wptr_d;
      wgray_q <= wptr_d ^ (wptr_d >> 1);
      if (ld_wr) begin
        offsel_q <= ~offsel_q;
        if (!offsel_q) begin
          eoff_q <= data_s[OFFS_W-1:0];
        end else begin
          foff_q <= data_s[OFFS_W-1:0];
        end
      end
    end
  end

  // Read pointer, output register and fall-through valid
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      rptr_q  <= '0;
      rgray_q <= '0;
      ov_q    <= 1'b0;
      dout_q  <= '0;
    end else begin
      rptr_q  <= rptr_d;
      rgray_q <= rptr_d ^ (rptr_d >> 1);
      ov_q    <= ov_d;
      if (rd_mem) begin
        dout_q <= mem_q[rptr_q[AW-1:0]];
      end
    end
  end

  // Empty or output-ready pin, updated on read edges only
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      empty_flag_n_o <= 1'b0;
    end else if (r_edge) begin
      if (first_word_fall_through) begin
        empty_flag_n_o <= ~ov_d;
      end else begin
        empty_flag_n_o <= (occ_rn != '0);
      end
    end
  end

  // Full or input-ready pin, updated on write edges only
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      full_flag_n_o <= 1'b1;
    end else if (w_edge) begin
      if (first_word_fall_through) begin
        full_flag_n_o <= (occ_wn == DEPTH_C);
      end else begin
        full_flag_n_o <= (occ_wn != DEPTH_C);
      end
    end
  end

  // Almost-empty: one clock when synchronous, split clocks when not
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      almost_empty_n_o <= 1'b0;
    end else if (sync_flags_q) begin
      if (r_edge) begin
        almost_empty_n_o <= pae_r;
      end
    end else if (r_edge && !pae_r) begin
      almost_empty_n_o <= 1'b0;
    end else if (w_edge && pae_w) begin
      almost_empty_n_o <= 1'b1;
    end
  end

  // Almost-full: asserted from writes, cleared from reads when asynchronous
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      almost_full_n_o <= 1'b1;
    end else if (sync_flags_q) begin
      if (w_edge) begin
        almost_full_n_o <= ~paf_w;
      end
    end else if (w_edge && paf_w) begin
      almost_full_n_o <= 1'b0;
    end else if (r_edge && !paf_r) begin
      almost_full_n_o <= 1'b1;
    end
  end

  // Half-full: set by writes above half, cleared by reads at or below
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      half_full_n_o <= 1'b1;
    end else if (w_edge && occ_wn > HALF_C) begin
      half_full_n_o <= 1'b0;
    end else if (r_edge && occ_rn <= HALF_C) begin
      half_full_n_o <= 1'b1;
    end
  end

  // Output drive follows output enable only; storage is untouched
  always_ff @(posedge clk_i) begin
    if (dev_rst) begin
      data_oe_o <= 1'b0;
      data_o    <= '0;
    end else begin
      data_oe_o <= ~pin_s[PIN_OE];
      data_o    <= dout_q;
    end
  end

  // Wishbone slave: ack one cycle after strobe, dropped the next
  wire wb_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wb_done = wb_cyc_i & wb_stb_i & wb_ack_o;   // Writes land on the edge that shows ack
  wire hit_ctl = (wb_adr_i == ADDR_CTRL);
  wire hit_st  = (wb_adr_i == ADDR_STATUS);
  wire hit_off = (wb_adr_i == ADDR_OFFSETS);
  wire hit_cnt = (wb_adr_i == ADDR_COUNT);
  wire [31:0] st_word = 32'(
    {ov_q, sync_flags_q, first_word_fall_through, half_full_n_o, almost_full_n_o,
     almost_empty_n_o, full_flag_n_o, empty_flag_n_o});
  wire [31:0] off_word = (32'(foff_q) << OFFS_FULL_LSB) | 32'(eoff_q);
  wire [31:0] cnt_word = 32'(occ_rn);
  wire [31:0] rd_word  = hit_ctl ? (32'(sync_flags_q) << CTRL_SYNC_BIT) :
                         hit_st  ? st_word :
                         hit_off ? off_word :
                         hit_cnt ? cnt_word : 32'h0000_0000; // Unmapped reads zero

  // Control register and bus answer; only software changes the flag timing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_flags_q <= CTRL_SYNC_RST;
      wb_ack_o     <= 1'b0;
      wb_dat_o     <= '0;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_word;
      end
      if (wb_done && wb_we_i && hit_ctl && wb_sel_i[0]) begin
        sync_flags_q <= wb_dat_i[CTRL_SYNC_BIT];
      end
    end
  end

  // Status bit positions match the packed status word above
  localparam int ST_CHECK = ST_EF + ST_FF + ST_PAE + ST_PAF + ST_HF + ST_FIRST_WORD_FALL_THROUGH + ST_SYNC + ST_OV;

endmodule : dcf_fifo

// *** dv/dcf_fifo_checker.sv ***
`timescale 1ns/1ps
module dcf_fifo_checker import dcf_pkg::*; (
  input wire logic clk_i,            // Clock
  input wire logic rst_i,            // Reset
  input wire logic reset_n_i,        // Pin reset
  input wire logic wclk_i,           // Write clock
  input wire logic rclk_i,           // Read clock
  input wire logic oe_n_i,           // Output enable
  input wire logic wb_cyc_i,         // Cycle
  input wire logic wb_stb_i,         // Strobe
  input wire logic wb_ack_o,         // Ack
  input wire logic data_oe_o,        // Driver enable
  input wire logic empty_flag_n_o,   // Empty
  input wire logic full_flag_n_o,    // Full
  input wire logic almost_empty_n_o, // Almost empty
  input wire logic almost_full_n_o,  // Almost full
  input wire logic half_full_n_o     // Half full
);
  logic [3:0] w_age_q, r_age_q, s_age_q;
  logic       w_prev_q, r_prev_q;
  function automatic logic [3:0] age_nx(input logic clr, input logic [3:0] a);
    return clr ? 4'h0 : a + {3'h0, a != 4'hF};
  endfunction : age_nx
  // Ages saturate so a stale flag move never wraps back into the window
  always_ff @(posedge clk_i) begin
    w_prev_q <= wclk_i;
    r_prev_q <= rclk_i;
    w_age_q  <= age_nx(wclk_i && !w_prev_q, w_age_q);
    r_age_q  <= age_nx(rclk_i && !r_prev_q, r_age_q);
    s_age_q  <= age_nx(rst_i || !reset_n_i, s_age_q);
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || s_age_q < 4'h8);
  AST_ACK_ANSWER: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack too long");
  AST_FULL_WCLK: assert property ($changed(full_flag_n_o) |-> w_age_q inside {[1:7]})
    else $error("full moved off write edge");
  AST_EMPTY_RCLK: assert property ($changed(empty_flag_n_o) |-> r_age_q inside {[1:7]})
    else $error("empty moved off read edge");
  AST_HF_SET: assert property ($fell(half_full_n_o) |-> w_age_q inside {[1:7]})
    else $error("half full set off write edge");
  AST_HF_CLR: assert property ($rose(half_full_n_o) |-> r_age_q inside {[1:7]})
    else $error("half full cleared off read edge");
  AST_AF_SET: assert property ($fell(almost_full_n_o) |-> w_age_q inside {[1:7]})
    else $error("almost full set off write edge");
  AST_AE_SET: assert property ($fell(almost_empty_n_o) |-> r_age_q inside {[1:7]})
    else $error("almost empty set off read edge");
  AST_OE_OFF: assert property (oe_n_i [*6] |-> !data_oe_o)
    else $error("driver on while disabled");
  AST_RST_FLAGS: assert property (disable iff (rst_i) !reset_n_i [*6] |->
    !empty_flag_n_o && full_flag_n_o && !almost_empty_n_o && half_full_n_o && almost_full_n_o)
    else $error("flags wrong in reset");
  COV_FULL: cover property ($fell(full_flag_n_o));
  COV_HALF: cover property ($fell(half_full_n_o));
  COV_ACK: cover property (wb_ack_o);
  COV_OE: cover property ($fell(data_oe_o));
endmodule : dcf_fifo_checker
bind dcf_fifo dcf_fifo_checker u_chk (.clk_i, .rst_i, .reset_n_i, .wclk_i, .rclk_i, .oe_n_i,
  .wb_cyc_i, .wb_stb_i, .wb_ack_o, .data_oe_o, .empty_flag_n_o, .full_flag_n_o,
  .almost_empty_n_o, .almost_full_n_o, .half_full_n_o);

// *** dv/dcf_link_model.sv ***
`timescale 1ns/1ps
module dcf_link_model import dcf_pkg::*; (
  input  wire logic         clk_i,   // System clock
  output logic              wclk_o,  // Write clock
  output logic              rclk_o,  // Read clock
  output logic              wen_n_o, // Write enable
  output logic              ld_n_o,  // Offset load
  output logic [DATA_W-1:0] data_o,  // Write data
  output logic              ren_n_o  // Read enable
);
  // Free-running link clocks; read side skewed so phases never line up
  initial begin
    wclk_o = 1'b0;
    forever #62.5 wclk_o = ~wclk_o;
  end
  initial begin
    rclk_o = 1'b0;
    #23.1;
    forever #62.5 rclk_o = ~rclk_o;
  end
  initial begin
    wen_n_o = 1'b1;
    ld_n_o  = 1'b1;
    data_o  = 18'h00000;
    ren_n_o = 1'b1;
  end
  // One word per write edge; released data shows its inverse
  task automatic put(input logic [DATA_W-1:0] d, input logic ld);
    @(negedge wclk_o);
    @(posedge clk_i);
    wen_n_o <= 1'b0;
    ld_n_o  <= ld;
    data_o  <= d;
    @(negedge wclk_o);
    @(posedge clk_i);
    wen_n_o <= 1'b1;
    ld_n_o  <= 1'b1;
    data_o  <= ~d;
  endtask : put
  // Enable held across exactly one read edge
  task automatic get();
    @(negedge rclk_o);
    @(posedge clk_i);
    ren_n_o <= 1'b0;
    @(negedge rclk_o);
    @(posedge clk_i);
    ren_n_o <= 1'b1;
  endtask : get
endmodule : dcf_link_model

// *** dv/tb_dual_clock_fifo_flag_logic.sv ***
`timescale 1ns/1ps
module tb_dual_clock_fifo_flag_logic;
  import dcf_pkg::*;
  localparam int D  = 32; // Short depth keeps the run brief
  localparam int NE = 4;
  localparam int NF = 6;
  localparam logic [31:0] DEF_OFFS = (D == SMALL_DEPTH) ? 32'h001F001F : 32'h007F003F;
  logic              clk, rst, reset_n, fl_n, rxi_n, wxi_n, oe_n, cyc, stb, we, ack;
  logic              wclk, rclk, wen_n, ld_n, ren_n, doe, ef, ff, ae, af, hf;
  logic [ADR_W-1:0]  adr;
  logic [31:0]       wdat, rdat, q;
  logic [DATA_W-1:0] din, dout, w;
  int                n_errors = 0;
  int                compares = 0;
  int                i;
  dcf_link_model link (.clk_i(clk), .wclk_o(wclk), .rclk_o(rclk), .wen_n_o(wen_n),
    .ld_n_o(ld_n), .data_o(din), .ren_n_o(ren_n));
  dcf_fifo #(.DEPTH(D)) dut (.clk_i(clk), .rst_i(rst), .reset_n_i(reset_n),
    .first_load_strap_n_i(fl_n), .read_expansion_in_n_i(rxi_n),
    .write_expansion_in_n_i(wxi_n), .wclk_i(wclk), .wen_n_i(wen_n), .offset_load_n_i(ld_n),
    .data_i(din), .rclk_i(rclk), .ren_n_i(ren_n), .oe_n_i(oe_n), .data_o(dout),
    .data_oe_o(doe), .empty_flag_n_o(ef), .full_flag_n_o(ff), .almost_empty_n_o(ae),
    .almost_full_n_o(af), .half_full_n_o(hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic close_out();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Request held until ack is sampled; read data taken at that edge
  task automatic wb(input logic wr, input logic [ADR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {1'b1, 1'b1, wr, a, d};
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'h0;
    @(posedge clk);
  endtask : wb
  // Flags need a sync plus a link edge on each side to land
  task automatic settle();
    repeat (40) @(posedge clk);
  endtask : settle
  task automatic flags(input int n);
    settle();
    chk("empty", 32'(n != 0), 32'(ef));
    chk("almost_empty", 32'(n > NE), 32'(ae));
    chk("half_full", 32'(n <= D / 2), 32'(hf));
    chk("almost_full", 32'(n < D - NF), 32'(af));
    chk("full", 32'(n != D), 32'(ff));
    wb(1'b0, ADDR_COUNT, '0);
    chk("count", 32'(n), q);
  endtask : flags
  task automatic pin_reset(input logic [2:0] s);
    @(posedge clk);
    reset_n <= 1'b0;
    {fl_n, rxi_n, wxi_n} <= s;
    repeat (40) @(posedge clk);
    reset_n <= 1'b1;
    repeat (40) @(posedge clk);
  endtask : pin_reset
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    close_out();
  end
  initial begin
    {rst, reset_n, fl_n, rxi_n, wxi_n, oe_n} = 6'h3E;
    {cyc, stb, we, adr, wdat} = '0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    pin_reset(3'h7);
    flags(0);
    wb(1'b0, ADDR_STATUS, '0);
    chk("status", 32'h0000001A, q);
    wb(1'b0, ADDR_OFFSETS, '0);
    chk("offsets", DEF_OFFS, q);
    wb(1'b0, 8'h10, '0);
    chk("unmapped", '0, q);
    wb(1'b1, ADDR_CTRL, 32'h00000001);
    wb(1'b0, ADDR_STATUS, '0);
    chk("sync", 32'h00000001, 32'(q[ST_SYNC]));
    link.put(DATA_W'(NE), 1'b0);
    link.put(DATA_W'(NF), 1'b0);
    wb(1'b0, ADDR_OFFSETS, '0);
    chk("offsets", (32'(NF) << OFFS_FULL_LSB) | 32'(NE), q);
    $display("test reset and offsets done");
    for (i = 1; i <= D + 1; i++) begin
      w = 18'h15000 | DATA_W'(i);
      link.put(w, 1'b1);
      flags(i > D ? D : i);
      chk("held", '0, 32'(dout));
    end
    $display("test fill done");
    // Fill ran with synchronous almost flags, the drain runs with split clocks
    wb(1'b1, ADDR_CTRL, '0);
    for (i = 1; i <= D + 1; i++) begin
      link.get();
      flags(i > D ? 0 : D - i);
      w = 18'h15000 | DATA_W'(i > D ? D : i);
      chk("data_o", 32'(w), 32'(dout));
    end
    chk("drive", 32'h00000001, 32'(doe));
    oe_n <= 1'b1;
    settle();
    chk("drive", '0, 32'(doe));
    wb(1'b0, ADDR_COUNT, '0);
    chk("count", '0, q);
    $display("test drain done");
    pin_reset(STRAP_FIRST_WORD_FALL_THROUGH);
    wb(1'b0, ADDR_STATUS, '0);
    chk("mode", 32'h00000001, 32'(q[ST_FIRST_WORD_FALL_THROUGH]));
    wb(1'b0, ADDR_OFFSETS, '0);
    chk("offsets", DEF_OFFS, q);
    chk("ready", 32'h00000001, 32'(ef));
    link.put(18'h2ABCD, 1'b1);
    settle();
    chk("fall", 32'h0002ABCD, 32'(dout));
    chk("ready", '0, 32'(ef));
    link.get();
    settle();
    chk("ready", 32'h00000001, 32'(ef));
    $display("test fall through done");
    close_out();
  end
endmodule : tb_dual_clock_fifo_flag_logic
